// ===== pkg/sample_queue_pkg.sv
// Constants for the sample queue: register indices, fields, sizes.
// Assumes a 32-bit AHB-Lite register bus; byte address is four times the index.
package sample_queue_pkg;
    localparam int unsigned QUEUE_DEPTH   = 128;
    localparam int unsigned PRESS_W       = 24;
    localparam int unsigned TEMP_W        = 16;
    localparam int unsigned SET_W         = PRESS_W + TEMP_W;
    localparam int unsigned PTR_W         = 7;
    localparam int unsigned CNT_W         = 8;
    localparam int unsigned IDX_W         = 8;
    // Register indices
    localparam logic [7:0] IDX_MODE_CTRL   = 8'h13;
    localparam logic [7:0] IDX_THRESHOLD   = 8'h14;
    localparam logic [7:0] IDX_STORED_CNT  = 8'h25;
    localparam logic [7:0] IDX_QUEUE_FLAGS = 8'h26;
    localparam logic [7:0] IDX_PRESS_RES   = 8'h28;
    localparam logic [7:0] IDX_TEMP_RES    = 8'h2B;
    localparam logic [7:0] IDX_QOUT_PRESS  = 8'h78;
    localparam logic [7:0] IDX_QOUT_TEMP   = 8'h7B;
    // Mode control fields
    localparam int unsigned MODE_LSB      = 0;
    localparam int unsigned MODE_MSB      = 1;
    localparam int unsigned TRIG_BIT      = 2;
    localparam int unsigned STOP_BIT      = 3;
    localparam int unsigned CTRL_W        = 4;
    localparam logic [1:0] MODE_BYPASS     = 2'h0;
    localparam logic [1:0] MODE_FILL       = 2'h1;
    localparam logic [1:0] MODE_STREAM_A   = 2'h2;
    localparam logic [1:0] MODE_STREAM_B   = 2'h3;
    localparam logic [CTRL_W-1:0] CTRL_RESET   = 4'h0;
    localparam int unsigned WTM_W         = 7;
    localparam logic [WTM_W-1:0] WTM_RESET    = 7'h00;
    // Queue flag fields
    localparam int unsigned FLAG_FULL_BIT = 5;
    localparam int unsigned FLAG_OVR_BIT  = 6;
    localparam int unsigned FLAG_THR_BIT  = 7;
    // AHB-Lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;
    localparam int unsigned ADDR_LSB      = 2;
    typedef enum logic [1:0] {BHV_BYPASS, BHV_FILL, BHV_STREAM} behaviour_e;
endpackage

// ===== logic/sample_slot_store.sv
// Flip-flop storage for queued sample sets, one write and one read index.
// Assumes the caller keeps indices in range; clear wipes every slot.
`timescale 1ns/100ps
module sample_slot_store #(
    parameter int unsigned WIDTH = 40,
    parameter int unsigned DEPTH = 128,
    parameter int unsigned AW    = 7
) (
    input  wire logic             clk_i,
    input  wire logic             clear_i,
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_idx_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic [AW-1:0]    rd_idx_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] slot_reg  [DEPTH];
    logic [WIDTH-1:0] slot_next [DEPTH];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            slot_next[i] = clear_i ? '0 : slot_reg[i];
        end
        if (wr_en_i && !clear_i) begin
            slot_next[wr_idx_i] = wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        slot_reg <= slot_next;
    end

    assign rd_data_o = slot_reg[rd_idx_i];
endmodule // sample_slot_store

// ===== logic/sample_queue_modes.sv
// Sample set queue with bypass, fill-and-stop, stream and triggered modes.
// Assumes samples and trigger come from logic on CORE_CLK_I; host on AHB-Lite.
`timescale 1ns/100ps
module sample_queue_modes #(
    parameter int unsigned DEPTH = sample_queue_pkg::QUEUE_DEPTH
) (
    input  wire logic                                CORE_CLK_I,
    input  wire logic                                RESET_I,
    input  wire logic                                HSEL_I,
    input  wire logic [31:0]                         HADDR_I,
    input  wire logic [1:0]                          HTRANS_I,
    input  wire logic                                HWRITE_I,
    input  wire logic [2:0]                          HSIZE_I,
    input  wire logic [31:0]                         HWDATA_I,
    input  wire logic                                HREADY_I,
    output logic      [31:0]                         HRDATA_O,
    output logic                                     HREADYOUT_O,
    output logic                                     HRESP_O,
    input  wire logic                                SAMPLE_VALID_I,
    input  wire logic [sample_queue_pkg::PRESS_W-1:0] SAMPLE_PRESS_I,
    input  wire logic [sample_queue_pkg::TEMP_W-1:0]  SAMPLE_TEMP_I,
    input  wire logic                                TRIGGER_EVENT_ACTIVE_I
);
    localparam int unsigned PW = sample_queue_pkg::PTR_W;
    localparam int unsigned CW = sample_queue_pkg::CNT_W;
    localparam int unsigned SW = sample_queue_pkg::SET_W;

    // Bus state
    logic                                    dphase_reg, dphase_next;
    logic                                    dwrite_reg, dwrite_next;
    logic [sample_queue_pkg::IDX_W-1:0]      didx_reg, didx_next;
    logic                                    rwait_reg, rwait_next;
    logic [31:0]                             rdata_reg, rdata_next;
    logic [sample_queue_pkg::CTRL_W-1:0]     ctrl_reg, ctrl_next;
    logic [sample_queue_pkg::WTM_W-1:0]      wtm_reg, wtm_next;
    logic                                    pop;

    // Queue state
    logic [PW-1:0]                           wr_ptr_reg, wr_ptr_next;
    logic [PW-1:0]                           rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0]                           count_reg, count_next;
    logic                                    full_flag_reg, full_flag_next;
    logic                                    ovr_flag_reg, ovr_flag_next;
    logic                                    fill_done_reg, fill_done_next;
    logic                                    trig_seen_reg, trig_seen_next;
    logic                                    trig_prev_reg, trig_prev_next;
    logic [sample_queue_pkg::PRESS_W-1:0]    press_res_reg, press_res_next;
    logic [sample_queue_pkg::TEMP_W-1:0]     temp_res_reg, temp_res_next;

    sample_queue_pkg::behaviour_e            behaviour;
    logic [1:0]                              mode_field;
    logic                                    bypass_code;
    logic [CW-1:0]                           depth_limit;
    logic                                    at_limit;
    logic                                    thr_flag;
    logic                                    store_en;
    logic [SW-1:0]                           head_set;
    logic                                    take;
    logic [sample_queue_pkg::IDX_W-1:0]      take_idx;

    // Address index of a byte address
    function automatic logic [sample_queue_pkg::IDX_W-1:0] to_idx(input logic [31:0] addr);
        to_idx = addr[sample_queue_pkg::ADDR_LSB +: sample_queue_pkg::IDX_W];
    endfunction

    assign mode_field  = ctrl_reg[sample_queue_pkg::MODE_MSB:sample_queue_pkg::MODE_LSB];
    assign bypass_code = (mode_field == sample_queue_pkg::MODE_BYPASS);

    // Mode decode with trigger staging
    always_comb begin
        behaviour = sample_queue_pkg::BHV_BYPASS;
        if (bypass_code) begin
            behaviour = sample_queue_pkg::BHV_BYPASS;
        end else if (!ctrl_reg[sample_queue_pkg::TRIG_BIT]) begin
            behaviour = (mode_field == sample_queue_pkg::MODE_FILL) ?
                sample_queue_pkg::BHV_FILL : sample_queue_pkg::BHV_STREAM;
        end else begin
            unique case (mode_field)
                sample_queue_pkg::MODE_FILL:
                    behaviour = trig_seen_reg ? sample_queue_pkg::BHV_FILL
                                              : sample_queue_pkg::BHV_BYPASS;
                sample_queue_pkg::MODE_STREAM_A:
                    behaviour = trig_seen_reg ? sample_queue_pkg::BHV_STREAM
                                              : sample_queue_pkg::BHV_BYPASS;
                default:
                    behaviour = trig_seen_reg ? sample_queue_pkg::BHV_FILL
                                              : sample_queue_pkg::BHV_STREAM;
            endcase
        end
    end

    // Usable depth; threshold of zero leaves the full depth
    always_comb begin
        depth_limit = CW'(DEPTH);
        if (ctrl_reg[sample_queue_pkg::STOP_BIT] && (wtm_reg != '0)) begin
            depth_limit = {1'b0, wtm_reg};
        end
    end
    assign at_limit = (count_reg >= depth_limit);
    assign thr_flag = (wtm_reg != '0) && (count_reg >= {1'b0, wtm_reg});

    // Bus data phase
    assign take     = HSEL_I && HREADY_I && HTRANS_I[1];
    assign take_idx = to_idx(HADDR_I);
    assign pop      = dphase_reg && !dwrite_reg && rwait_reg
                      && (didx_reg == sample_queue_pkg::IDX_QOUT_TEMP) && (count_reg != '0);

    always_comb begin
        dphase_next = dphase_reg;
        dwrite_next = dwrite_reg;
        didx_next   = didx_reg;
        rwait_next  = 1'b0;
        rdata_next  = rdata_reg;
        ctrl_next   = ctrl_reg;
        wtm_next    = wtm_reg;
        if (dphase_reg && dwrite_reg) begin
            unique case (didx_reg)
                sample_queue_pkg::IDX_MODE_CTRL:
                    ctrl_next = HWDATA_I[sample_queue_pkg::CTRL_W-1:0];
                sample_queue_pkg::IDX_THRESHOLD:
                    wtm_next = HWDATA_I[sample_queue_pkg::WTM_W-1:0];
                default: ;
            endcase
        end
        if (dphase_reg && !dwrite_reg && !rwait_reg) begin
            // One wait state so read data leaves a flip-flop
            rwait_next = 1'b1;
            rdata_next = '0;
            unique case (didx_reg)
                sample_queue_pkg::IDX_MODE_CTRL:   rdata_next = 32'(ctrl_reg);
                sample_queue_pkg::IDX_THRESHOLD:   rdata_next = 32'(wtm_reg);
                sample_queue_pkg::IDX_STORED_CNT:  rdata_next = 32'(count_reg);
                sample_queue_pkg::IDX_QUEUE_FLAGS: begin
                    rdata_next[sample_queue_pkg::FLAG_FULL_BIT] = full_flag_reg;
                    rdata_next[sample_queue_pkg::FLAG_OVR_BIT]  = ovr_flag_reg;
                    rdata_next[sample_queue_pkg::FLAG_THR_BIT]  = thr_flag;
                end
                sample_queue_pkg::IDX_PRESS_RES:   rdata_next = 32'(press_res_reg);
                sample_queue_pkg::IDX_TEMP_RES:    rdata_next = 32'(temp_res_reg);
                sample_queue_pkg::IDX_QOUT_PRESS:
                    rdata_next = 32'(head_set[SW-1 -: sample_queue_pkg::PRESS_W]);
                sample_queue_pkg::IDX_QOUT_TEMP:
                    rdata_next = 32'(head_set[sample_queue_pkg::TEMP_W-1:0]);
                default: ;
            endcase
        end
        if (HREADYOUT_O) begin
            dphase_next = take;
            dwrite_next = HWRITE_I;
            didx_next   = take_idx;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            didx_reg   <= '0;
            rwait_reg  <= 1'b0;
            rdata_reg  <= '0;
            ctrl_reg   <= sample_queue_pkg::CTRL_RESET;
            wtm_reg    <= sample_queue_pkg::WTM_RESET;
        end else begin
            dphase_reg <= dphase_next;
            dwrite_reg <= dwrite_next;
            didx_reg   <= didx_next;
            rwait_reg  <= rwait_next;
            rdata_reg  <= rdata_next;
            ctrl_reg   <= ctrl_next;
            wtm_reg    <= wtm_next;
        end
    end

    assign HREADYOUT_O = !(dphase_reg && !dwrite_reg && !rwait_reg);
    assign HRDATA_O    = rdata_reg;
    assign HRESP_O     = sample_queue_pkg::HRESP_OKAY;

    // Queue engine
    always_comb begin
        wr_ptr_next    = wr_ptr_reg;
        rd_ptr_next    = rd_ptr_reg;
        count_next     = count_reg;
        full_flag_next = full_flag_reg;
        ovr_flag_next  = ovr_flag_reg;
        fill_done_next = fill_done_reg;
        trig_prev_next = TRIGGER_EVENT_ACTIVE_I;
        trig_seen_next = trig_seen_reg;
        store_en       = 1'b0;
        press_res_next = press_res_reg;
        temp_res_next  = temp_res_reg;
        if (TRIGGER_EVENT_ACTIVE_I && !trig_prev_reg) begin
            trig_seen_next = 1'b1;
        end
        if (SAMPLE_VALID_I) begin
            press_res_next = SAMPLE_PRESS_I;
            temp_res_next  = SAMPLE_TEMP_I;
            full_flag_next = 1'b0;
        end
        if (pop) begin
            rd_ptr_next = rd_ptr_reg + PW'(1);
            count_next  = count_reg - CW'(1);
        end
        if (SAMPLE_VALID_I) begin
            unique case (behaviour)
                sample_queue_pkg::BHV_FILL: begin
                    // Stays stopped even after reads, until bypass
                    if (!fill_done_reg && !at_limit) begin
                        store_en = 1'b1;
                    end
                end
                sample_queue_pkg::BHV_STREAM: begin
                    store_en = 1'b1;
                    ovr_flag_next = 1'b0;
                    if (at_limit && !pop) begin
                        rd_ptr_next   = rd_ptr_reg + PW'(1);
                        ovr_flag_next = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (store_en) begin
            wr_ptr_next = wr_ptr_reg + PW'(1);
            if (!(at_limit && !pop && behaviour == sample_queue_pkg::BHV_STREAM)) begin
                count_next = count_next + CW'(1);
                if (count_next == depth_limit) begin
                    full_flag_next = 1'b1;
                    if (behaviour == sample_queue_pkg::BHV_FILL) begin
                        fill_done_next = 1'b1;
                    end
                end
            end
        end
        if (bypass_code) begin
            wr_ptr_next    = '0;
            rd_ptr_next    = '0;
            count_next     = '0;
            full_flag_next = 1'b0;
            ovr_flag_next  = 1'b0;
            fill_done_next = 1'b0;
            trig_seen_next = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            full_flag_reg <= 1'b0;
            ovr_flag_reg  <= 1'b0;
            fill_done_reg <= 1'b0;
            trig_seen_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
            press_res_reg <= '0;
            temp_res_reg  <= '0;
        end else begin
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            count_reg     <= count_next;
            full_flag_reg <= full_flag_next;
            ovr_flag_reg  <= ovr_flag_next;
            fill_done_reg <= fill_done_next;
            trig_seen_reg <= trig_seen_next;
            trig_prev_reg <= trig_prev_next;
            press_res_reg <= press_res_next;
            temp_res_reg  <= temp_res_next;
        end
    end

    sample_slot_store #(
        .WIDTH (SW),
        .DEPTH (DEPTH),
        .AW    (PW)
    ) u_store (
        .clk_i     (CORE_CLK_I),
        .clear_i   (bypass_code),
        .wr_en_i   (store_en),
        .wr_idx_i  (wr_ptr_reg),
        .wr_data_i ({SAMPLE_PRESS_I, SAMPLE_TEMP_I}),
        .rd_idx_i  (rd_ptr_reg),
        .rd_data_o (head_set)
    );

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    a_bypass_clears: assert property (bypass_code |=> count_reg == '0)
        else $error("Bypass left entries in the queue");
    a_fill_stops: assert property (
        (behaviour == sample_queue_pkg::BHV_FILL) && at_limit
        && SAMPLE_VALID_I && !pop && !bypass_code |=> $stable(count_reg))
        else $error("Fill mode stored past its limit");
    a_stream_overwrite: assert property (
        (behaviour == sample_queue_pkg::BHV_STREAM)
        && at_limit && SAMPLE_VALID_I && !pop && !bypass_code
        |=> $stable(count_reg) && ovr_flag_reg)
        else $error("Stream overwrite not flagged");
    a_full_rises: assert property (
        store_en && !bypass_code && !at_limit && !pop
        && (count_reg + CW'(1) == depth_limit) |=> full_flag_reg)
        else $error("Full flag missed");
    a_full_period: assert property (
        full_flag_reg && SAMPLE_VALID_I && !store_en |=> !full_flag_reg)
        else $error("Full flag outlived one period");
    a_thr_zero: assert property (wtm_reg == '0 |-> !thr_flag)
        else $error("Threshold flag set with zero level");
    a_trig_holds: assert property (
        trig_seen_reg && !bypass_code |=> trig_seen_reg || $past(bypass_code))
        else $error("Triggered behaviour dropped");
    a_trig_edge: assert property (
        !bypass_code && TRIGGER_EVENT_ACTIVE_I && !trig_prev_reg
        ##1 !bypass_code |-> trig_seen_reg)
        else $error("Trigger edge missed");
    a_bypass_stage: assert property (
        ctrl_reg[sample_queue_pkg::TRIG_BIT] && !trig_seen_reg
        && (mode_field != sample_queue_pkg::MODE_STREAM_B) && SAMPLE_VALID_I |-> !store_en)
        else $error("Stored while waiting for trigger");
endmodule // sample_queue_modes

// ===== verif/queue_host_model.sv
// Host processor model: single-word AHB-Lite master for the queue registers.
// Assumes one slave whose HREADYOUT is fed back as HREADY; callers enter after a rising edge.
`timescale 1ns/100ps
module queue_host_model (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic      [31:0] haddr_o,
    output logic      [1:0]  htrans_o,
    output logic             hwrite_o,
    output logic      [2:0]  hsize_o,
    output logic      [31:0] hwdata_o
);
    initial begin
        hsel_o   = 1'b0;
        haddr_o  = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o  = 3'h2;
        hwdata_o = 32'h0;
    end

    // Ready and data taken at the rising edge, before the slave's registers move
    task automatic wait_ready(output logic [31:0] d);
        logic r;
        do begin
            @(posedge clk_i);
            r = hready_i;
            d = hrdata_i;
        end while (r !== 1'b1);
    endtask

    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel_o   <= 1'b1;
        haddr_o  <= {22'h0, idx, 2'h0};
        htrans_o <= sample_queue_pkg::HTRANS_NONSEQ;
        hwrite_o <= wr;
        wait_ready(rd);
        hsel_o   <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= wd;
        wait_ready(rd);
    endtask

    // Queue mode changes always pass through bypass first
    task automatic set_mode(input logic [3:0] c);
        logic [31:0] d;
        xfer(1'b1, sample_queue_pkg::IDX_MODE_CTRL, 32'h0, d);
        xfer(1'b1, sample_queue_pkg::IDX_MODE_CTRL, {28'h0, c}, d);
    endtask
endmodule // queue_host_model

// ===== verif/sample_queue_modes_tb.sv
// Self-checking bench for the sample queue: host model on the bus, bench feeds samples.
// Assumes the design at its full depth; reads pop only on the temperature word.
`timescale 1ns/100ps
module sample_queue_modes_tb;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        valid = 1'b0;
    logic [23:0] press = 24'h0;
    logic [15:0] temp = 16'h0;
    logic        trig = 1'b0;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #2 core_clk = ~core_clk;

    queue_host_model u_queue_host_model (.clk_i(core_clk), .hready_i(hready),
        .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

    sample_queue_modes u_sample_queue_modes (.CORE_CLK_I(core_clk), .RESET_I(reset),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .SAMPLE_VALID_I(valid),
        .SAMPLE_PRESS_I(press), .SAMPLE_TEMP_I(temp), .TRIGGER_EVENT_ACTIVE_I(trig));

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Ceiling well above the two hundred or so cycles the scenarios need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic expect_reg(input logic [7:0] idx, input logic [31:0] mask,
                              input logic [31:0] exp);
        logic [31:0] d;
        u_queue_host_model.xfer(1'b0, idx, 32'h0, d);
        comparisons++;
        if ((d & mask) !== exp) begin
            n_mismatch++;
            $display("ERROR %0t reg %h read %h expected %h", $time, idx, d & mask, exp);
        end
        comparisons++;
        if (hresp !== sample_queue_pkg::HRESP_OKAY) begin
            n_mismatch++;
            $display("ERROR %0t response not OKAY", $time);
        end
    endtask

    task automatic write_reg(input logic [7:0] idx, input logic [31:0] v);
        logic [31:0] d;
        u_queue_host_model.xfer(1'b1, idx, v, d);
    endtask

    task automatic push(input logic [23:0] p, input int n);
        for (int i = 0; i < n; i++) begin
            valid <= 1'b1;
            press <= p + 24'(i);
            temp  <= 16'hBEEF;
            @(posedge core_clk);
            valid <= 1'b0;
            @(posedge core_clk);
        end
    endtask

    task automatic pulse_trigger();
        trig <= 1'b1;
        @(posedge core_clk);
        trig <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic test_bypass();
        expect_reg(sample_queue_pkg::IDX_MODE_CTRL, 32'hF, 32'h0);
        push(24'h123456, 1);
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'h0);
        expect_reg(sample_queue_pkg::IDX_PRESS_RES, 32'hFFFFFF, 32'h123456);
        expect_reg(8'h40, 32'hFFFFFFFF, 32'h0);
    endtask

    task automatic test_fill();
        write_reg(sample_queue_pkg::IDX_THRESHOLD, 32'h3);
        u_queue_host_model.set_mode(4'h9);
        push(24'h000001, 3);
        expect_reg(sample_queue_pkg::IDX_QUEUE_FLAGS, 32'hA0, 32'hA0);
        push(24'h000010, 2);
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'h3);
        expect_reg(sample_queue_pkg::IDX_QOUT_PRESS, 32'hFFFFFF, 32'h1);
        expect_reg(sample_queue_pkg::IDX_QOUT_TEMP, 32'hFFFF, 32'hBEEF);
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'h2);
        expect_reg(sample_queue_pkg::IDX_QUEUE_FLAGS, 32'h80, 32'h0);
        push(24'h000040, 1);
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'h2);
        for (int i = 2; i < 4; i++) begin
            expect_reg(sample_queue_pkg::IDX_QOUT_PRESS, 32'hFFFFFF, 32'(i));
            expect_reg(sample_queue_pkg::IDX_QOUT_TEMP, 32'hFFFF, 32'hBEEF);
        end
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'h0);
    endtask

    task automatic test_stream();
        write_reg(sample_queue_pkg::IDX_MODE_CTRL, 32'h0);
        write_reg(sample_queue_pkg::IDX_THRESHOLD, 32'h2);
        u_queue_host_model.set_mode(4'hA);
        push(24'h000011, 3);
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'h2);
        expect_reg(sample_queue_pkg::IDX_QUEUE_FLAGS, 32'hC0, 32'hC0);
        expect_reg(sample_queue_pkg::IDX_QOUT_PRESS, 32'hFFFFFF, 32'h12);
        expect_reg(sample_queue_pkg::IDX_QOUT_TEMP, 32'hFFFF, 32'hBEEF);
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'h1);
        push(24'h000014, 1);
        expect_reg(sample_queue_pkg::IDX_QOUT_PRESS, 32'hFFFFFF, 32'h13);
        expect_reg(sample_queue_pkg::IDX_QUEUE_FLAGS, 32'h60, 32'h20);
    endtask

    task automatic test_triggered(input logic [3:0] code, input int pre, input int after);
        write_reg(sample_queue_pkg::IDX_MODE_CTRL, 32'h0);
        write_reg(sample_queue_pkg::IDX_THRESHOLD, 32'h0);
        u_queue_host_model.set_mode(code);
        push(24'h000020, 1);
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'(pre));
        pulse_trigger();
        push(24'h000030, after);
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'(pre + after));
        expect_reg(sample_queue_pkg::IDX_QUEUE_FLAGS, 32'h80, 32'h0);
        write_reg(sample_queue_pkg::IDX_MODE_CTRL, 32'h0);
        expect_reg(sample_queue_pkg::IDX_STORED_CNT, 32'hFF, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        test_bypass();
        test_fill();
        test_stream();
        test_triggered(4'h6, 0, 2);
        test_triggered(4'h5, 0, 1);
        test_triggered(4'h7, 1, 2);
        stop_test();
    end
endmodule // sample_queue_modes_tb
